/* core/sfc_params.svh */
`ifndef SFC_PARAMS_SVH
`define SFC_PARAMS_SVH
// position code width and the most negative code (secure position unused)
`define SFC_POS_W 11
`define SFC_POS_MOST_NEG 11'h400
// motor parameter write, data byte 7 bit positions
`define SFC_PWM_RATE_BIT 6
`define SFC_PWM_DITHER_BIT 0
// pwm periods at 125 MHz for 22.8 kHz and 45.6 kHz
`define SFC_PWM_SLOW_NS 43860
`define SFC_PWM_FAST_NS 21930
`define SFC_PWM_SLOW_CYC (`SFC_PWM_SLOW_NS / 8)
`define SFC_PWM_FAST_CYC (`SFC_PWM_FAST_NS / 8)
// stabilisation time after deceleration, in microseconds
`define SFC_STAB_US 16
`define SFC_STAB_CYC ((`SFC_STAB_US * 1000) / 8)
// full-duty persistence that counts as an open coil, in microseconds
`define SFC_OPEN_US 100
`define SFC_OPEN_CYC ((`SFC_OPEN_US * 1000) / 8)
// reset values
`define SFC_ACCEL_SHAPE_RST 1'b0
`define SFC_VEL_RST 4'h0
`endif

/* core/sfc_pkg.sv */
`default_nettype none
package sfc_pkg;
	// controller states, one-hot
	typedef enum logic [5:0] {
		SFC_STOPPED = 6'h01,
		SFC_MOVING = 6'h02,
		SFC_TWO_PHASE = 6'h04,
		SFC_IMM_HALT = 6'h08,
		SFC_RAMPED_HALT = 6'h10,
		SFC_SHUTDOWN = 6'h20
	} sfc_state_t;
	// coil current mode
	typedef enum logic [1:0] {
		SFC_CUR_OFF = 2'h0,
		SFC_CUR_HOLD = 2'h1,
		SFC_CUR_RUN = 2'h2,
		SFC_CUR_STAB = 2'h3
	} sfc_cur_t;
	// one-cycle command strobes from the bus front end
	typedef struct packed {
		logic full_status_read_cmd;
		logic restore_defaults_cmd;
		logic motor_param_write_cmd;
		logic stall_param_write_cmd;
		logic set_target_cmd;
		logic go_secure_cmd;
		logic clear_position_cmd;
		logic two_phase_move_cmd;
		logic imm_halt_cmd;
		logic ramped_halt_cmd;
	} sfc_cmd_t;
	// analog monitor conditions
	typedef struct packed {
		logic thermal;
		logic deep_uv;
		logic cp_low;
		logic vdrop;
		logic full_duty;
		logic logic_reset;
	} sfc_mon_t;
	// flags reported by the full status read
	typedef struct packed {
		logic thermal_shutdown_flag;
		logic deep_undervoltage_flag;
		logic cp_fail_flag;
		logic coil_defect_flag;
		logic logic_supply_reset_flag;
		logic elec_fault_flag;
		logic step_lost_flag;
		logic halt_exit_flag;
		logic secure_position_valid;
	} sfc_flags_t;
	// velocity pair
	typedef struct packed {
		logic [3:0] vmax;
		logic [3:0] vmin;
	} sfc_vel_t;
endpackage : sfc_pkg
`default_nettype wire

/* core/sfc_sticky.sv */
`default_nettype none
`include "sfc_params.svh"
// sticky fault flag: set by condition, cleared by status read once it is gone
module sfc_sticky (
	input wire logic clock,
	input wire logic resetn,
	input wire logic cond,
	input wire logic clr,
	output logic flag
);
	typedef struct packed {
		logic f;
	} sfc_sticky_st_t;
	sfc_sticky_st_t s_q, s_d;
	// set wins over clear, so an event in the read cycle survives
	always_comb begin
		s_d = s_q;
		if (cond) begin
			s_d.f = 1'b1;
		end else if (clr) begin
			s_d.f = 1'b0;
		end
	end
	always_ff @(posedge clock) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign flag = s_q.f;
endmodule // sfc_sticky
`default_nettype wire

/* core/sfc_timer.sv */
`default_nettype none
`include "sfc_params.svh"
// down counter: load starts, done pulses when it reaches one
module sfc_timer #(
	parameter logic [15:0] COUNT = 16'h0001
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic run,
	output logic done
);
	typedef struct packed {
		logic [15:0] cnt;
	} sfc_timer_st_t;
	sfc_timer_st_t s_q, s_d;
	// counts while run holds, restarts when run drops
	always_comb begin
		s_d = s_q;
		if (!run) begin
			s_d.cnt = COUNT;
		end else if (s_q.cnt != 16'h0000) begin
			s_d.cnt = s_q.cnt - 16'h0001;
		end
	end
	always_ff @(posedge clock) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign done = run && (s_q.cnt == 16'h0001);
endmodule // sfc_timer
`default_nettype wire

/* core/sfc_control.sv */
`default_nettype none
`include "sfc_params.svh"
module sfc_control (
	input wire logic clock,
	input wire logic resetn,
	input wire sfc_pkg::sfc_cmd_t cmd, // command strobes
	input wire logic [7:0] param_byte7, // data byte 7 of a parameter write
	input wire sfc_pkg::sfc_vel_t ram_vel_in, // velocities carried by a parameter write
	input wire sfc_pkg::sfc_vel_t dual_vel_in, // velocities in a two-phase command
	input wire logic [1:0] dual_vel_given, // which two-phase fields were supplied
	input wire logic [10:0] cmd_position, // target from set-target
	input wire logic [10:0] secure_position, // secure position register
	input wire logic [10:0] actual_position, // position counter
	input wire logic motion_done, // ramp finished
	input wire logic second_motion, // two-phase in second motion
	input wire sfc_pkg::sfc_mon_t mon, // analog monitors
	input wire logic [1:0] vdrop_bridge, // bridge with the drop, x then y
	output logic [10:0] target_position,
	output sfc_pkg::sfc_state_t state,
	output sfc_pkg::sfc_flags_t flags,
	output sfc_pkg::sfc_vel_t status_vel, // velocities reported on status read
	output sfc_pkg::sfc_vel_t active_vel, // velocities driving the ramp
	output logic accel_shape_bit,
	output logic pwm_rate_select,
	output logic pwm_dither_enable,
	output logic [15:0] pwm_period, // pwm period in cycles
	output sfc_pkg::sfc_cur_t coil_current, // current reference mode
	output logic [10:0] current_angle, // angle for sine and cosine
	output logic [1:0] bridge_enable // per-bridge drive enable
);
	typedef struct packed {
		sfc_pkg::sfc_state_t st;
		sfc_pkg::sfc_mon_t mon;
		logic [10:0] tag;
		sfc_pkg::sfc_vel_t ram_vel;
		sfc_pkg::sfc_vel_t dual_vel;
		logic ram_shape;
		logic shape;
		logic rate;
		logic dither;
		logic [15:0] period;
		sfc_pkg::sfc_cur_t cur;
		logic [10:0] angle;
		logic [1:0] br;
		logic step_lost;
		logic halt_exit;
		logic sec_ok;
		logic elec;
		logic por_seen;
		sfc_pkg::sfc_vel_t act; // velocities driving the ramp, registered
	} sfc_ctl_st_t;
	sfc_ctl_st_t s_q, s_d;
	// fault flags from the sticky cells
	logic f_tsd, f_uv, f_cp, f_def, f_vdd;
	logic clr_rd; // full status read strobe
	logic stab_done; // stabilisation time elapsed
	logic open_done; // full duty has persisted
	logic causes; // any shutdown cause flagged
	assign clr_rd = cmd.full_status_read_cmd;
	// each flag waits for a read and for its condition to go away
	sfc_sticky u_tsd (.clock(clock), .resetn(resetn), .cond(s_q.mon.thermal), .clr(clr_rd),
		.flag(f_tsd));
	sfc_sticky u_uv (.clock(clock), .resetn(resetn), .cond(s_q.mon.deep_uv), .clr(clr_rd),
		.flag(f_uv));
	sfc_sticky u_cp (.clock(clock), .resetn(resetn), .cond(s_q.mon.cp_low), .clr(clr_rd),
		.flag(f_cp));
	sfc_sticky u_def (.clock(clock), .resetn(resetn),
		.cond(s_q.mon.vdrop || open_done), .clr(clr_rd), .flag(f_def));
	sfc_sticky u_vdd (.clock(clock), .resetn(resetn),
		.cond(s_q.mon.logic_reset || !s_q.por_seen), .clr(clr_rd), .flag(f_vdd));
	// stabilisation and open-coil timers
	// the open-coil timer runs only while a bridge drives; a floating one shows no duty
	sfc_timer #(.COUNT(16'(`SFC_STAB_CYC))) u_stab (.clock(clock), .resetn(resetn),
		.run(s_q.cur == sfc_pkg::SFC_CUR_STAB), .done(stab_done));
	sfc_timer #(.COUNT(16'(`SFC_OPEN_CYC))) u_open (.clock(clock), .resetn(resetn),
		.run(s_q.mon.full_duty && s_q.br != 2'b00), .done(open_done));
	// any latched cause, watched by the shutdown assertion
	assign causes = f_tsd || f_uv || f_def || f_cp;
	// next-state logic
	always_comb begin
		s_d = s_q;
		s_d.mon = mon;
		s_d.por_seen = 1'b1;
		// summary lags the flags by one edge, like every registered output
		s_d.elec = f_cp || f_uv || f_def || f_vdd;
		s_d.sec_ok = (secure_position != `SFC_POS_MOST_NEG);
		// parameter writes land in ram; two-phase keeps its own copy
		if (cmd.motor_param_write_cmd) begin
			s_d.ram_vel = ram_vel_in;
			s_d.rate = param_byte7[`SFC_PWM_RATE_BIT];
		end
		if (cmd.motor_param_write_cmd || cmd.stall_param_write_cmd) begin
			s_d.dither = param_byte7[`SFC_PWM_DITHER_BIT];
		end
		if (cmd.restore_defaults_cmd) begin
			s_d.ram_shape = `SFC_ACCEL_SHAPE_RST;
			s_d.ram_vel = {`SFC_VEL_RST, `SFC_VEL_RST};
		end
		// period follows the new select in the same edge
		s_d.period = s_d.rate ? 16'(`SFC_PWM_FAST_CYC) : 16'(`SFC_PWM_SLOW_CYC);
		// stop flag clears on first edge in stopped
		if (s_q.st == sfc_pkg::SFC_STOPPED) begin
			s_d.halt_exit = 1'b0;
		end
		// stepping loss: set-target and go-secure dropped while flagged
		if (cmd.set_target_cmd && !s_q.step_lost && (s_q.st == sfc_pkg::SFC_STOPPED
			|| s_q.st == sfc_pkg::SFC_MOVING || s_q.st == sfc_pkg::SFC_TWO_PHASE)) begin
			s_d.tag = cmd_position;
		end
		if (cmd.go_secure_cmd && !s_q.step_lost && s_q.sec_ok && (s_q.st ==
			sfc_pkg::SFC_STOPPED || s_q.st == sfc_pkg::SFC_MOVING)) begin
			s_d.tag = secure_position;
		end
		if (cmd.clear_position_cmd && (s_q.st == sfc_pkg::SFC_STOPPED
			|| s_q.st == sfc_pkg::SFC_SHUTDOWN)) begin
			s_d.tag = 11'h000;
		end
		// nothing else clears step lost; a hard halt sets it again
		if (clr_rd) begin
			s_d.step_lost = 1'b0;
		end
		// accel shape: ram value, but forced high in the second motion
		s_d.shape = (s_q.st == sfc_pkg::SFC_TWO_PHASE && second_motion) ? 1'b1
			: s_d.ram_shape;
		// current hand-over
		if (s_q.cur == sfc_pkg::SFC_CUR_STAB && stab_done) begin
			s_d.cur = sfc_pkg::SFC_CUR_HOLD;
			s_d.angle = s_q.tag;
		end
		// state transitions: faults first, then commands, except that a hard halt beats overheating
		unique case (s_q.st)
			sfc_pkg::SFC_STOPPED: begin
				// priority: faults, halt-exit wait, commands, then mismatch
				if (f_cp || f_uv || f_def) begin
					s_d.st = sfc_pkg::SFC_SHUTDOWN;
				end else if (f_tsd) begin
					s_d.st = sfc_pkg::SFC_SHUTDOWN;
				end else if (s_q.halt_exit) begin
					s_d.st = sfc_pkg::SFC_STOPPED;
				end else if (cmd.two_phase_move_cmd) begin
					s_d.st = sfc_pkg::SFC_TWO_PHASE;
					s_d.dual_vel = s_q.ram_vel;
					if (dual_vel_given[1]) begin
						s_d.dual_vel.vmax = dual_vel_in.vmax;
					end
					if (dual_vel_given[0]) begin
						s_d.dual_vel.vmin = dual_vel_in.vmin;
					end
				end else if (s_d.tag != actual_position && s_q.cur == sfc_pkg::SFC_CUR_HOLD) begin
					s_d.st = sfc_pkg::SFC_MOVING;
				end
			end
			sfc_pkg::SFC_MOVING, sfc_pkg::SFC_TWO_PHASE: begin
				if (f_cp || f_uv || f_def || cmd.imm_halt_cmd) begin
					s_d.st = sfc_pkg::SFC_IMM_HALT;
					s_d.step_lost = 1'b1;
				end else if (f_tsd || (cmd.ramped_halt_cmd && s_q.st == sfc_pkg::SFC_MOVING)) begin
					// overheating ramps down rather than losing steps
					s_d.st = sfc_pkg::SFC_RAMPED_HALT;
				end else if (motion_done) begin
					// a finished ramp holds its dc level first
					s_d.st = sfc_pkg::SFC_STOPPED;
					s_d.cur = sfc_pkg::SFC_CUR_STAB;
				end
			end
			sfc_pkg::SFC_IMM_HALT, sfc_pkg::SFC_RAMPED_HALT: begin
				if (motion_done) begin
					s_d.st = sfc_pkg::SFC_STOPPED;
					// target takes the stopping point
					s_d.tag = actual_position;
					s_d.halt_exit = 1'b1;
					s_d.cur = sfc_pkg::SFC_CUR_STAB;
				end
			end
			sfc_pkg::SFC_SHUTDOWN: begin
				s_d.tag = actual_position;
				s_d.cur = sfc_pkg::SFC_CUR_OFF;
				// a read with every cause gone releases the bridges
				// full duty still seen counts as the open coil persisting
				if (clr_rd && !s_q.mon.thermal && !s_q.mon.deep_uv && !s_q.mon.cp_low
					&& !s_q.mon.vdrop && !s_q.mon.full_duty
					&& !open_done) begin
					s_d.st = sfc_pkg::SFC_STOPPED;
					s_d.cur = sfc_pkg::SFC_CUR_HOLD;
					s_d.angle = actual_position;
				end
			end
			default: begin
				// an illegal code parks the motor with the bridges off
				s_d.st = sfc_pkg::SFC_SHUTDOWN;
			end
		endcase
		// start of motion goes straight to run at the first step angle
		if (s_d.st == sfc_pkg::SFC_MOVING || s_d.st == sfc_pkg::SFC_TWO_PHASE) begin
			s_d.cur = sfc_pkg::SFC_CUR_RUN;
			s_d.angle = actual_position;
		end
		// bridges: float in shutdown; a drop opens only its own bridge
		if (s_d.st == sfc_pkg::SFC_SHUTDOWN) begin
			s_d.br = 2'b00;
		end else begin
			// drive both otherwise
			s_d.br = 2'b11;
		end
		if (s_q.mon.vdrop) begin
			s_d.br = s_d.br & ~vdrop_bridge;
		end
		// ramp velocities: the two-phase copy only while that sequence runs
		s_d.act = (s_d.st == sfc_pkg::SFC_TWO_PHASE) ? s_d.dual_vel : s_d.ram_vel;
	end
	// state register; reset lands in shutdown
	always_ff @(posedge clock) begin
		if (!resetn) begin
			s_q <= '0;
			// the master must read status before the bridges drive again
			s_q.st <= sfc_pkg::SFC_SHUTDOWN;
		end else begin
			s_q <= s_d;
		end
	end
	// outputs straight from the state register and the sticky cells
	assign state = s_q.st;
	assign target_position = s_q.tag;
	assign accel_shape_bit = s_q.shape;
	assign pwm_rate_select = s_q.rate;
	assign pwm_dither_enable = s_q.dither;
	assign pwm_period = s_q.period;
	assign coil_current = s_q.cur;
	assign current_angle = s_q.angle;
	assign bridge_enable = s_q.br;
	assign status_vel = s_q.ram_vel;
	assign active_vel = s_q.act;
	assign flags = '{thermal_shutdown_flag: f_tsd, deep_undervoltage_flag: f_uv,
		cp_fail_flag: f_cp, coil_defect_flag: f_def, logic_supply_reset_flag: f_vdd,
		elec_fault_flag: s_q.elec, step_lost_flag: s_q.step_lost,
		halt_exit_flag: s_q.halt_exit, secure_position_valid: s_q.sec_ok};
	// assertions
	a_shutdown_exit: assert property (@(posedge clock) disable iff (!resetn)
		$past(s_q.st) == sfc_pkg::SFC_SHUTDOWN && s_q.st != sfc_pkg::SFC_SHUTDOWN
		|-> $past(clr_rd)) else $error("shutdown left without status read");
	a_step_lost_hold: assert property (@(posedge clock) disable iff (!resetn)
		s_q.step_lost && !clr_rd |=> s_q.step_lost)
		else $error("step lost cleared without read");
	a_target_locked: assert property (@(posedge clock) disable iff (!resetn)
		s_q.step_lost && !cmd.clear_position_cmd && s_q.st != sfc_pkg::SFC_SHUTDOWN
		&& !motion_done |=> $stable(s_q.tag)) else $error("target changed under loss");
	a_sec_valid: assert property (@(posedge clock) disable iff (!resetn)
		##1 flags.secure_position_valid == ($past(secure_position) != `SFC_POS_MOST_NEG))
		else $error("secure valid wrong");
	a_halt_exit_clr: assert property (@(posedge clock) disable iff (!resetn)
		s_q.halt_exit && s_q.st == sfc_pkg::SFC_STOPPED |=> !s_q.halt_exit)
		else $error("halt exit not cleared");
	a_bridges_off: assert property (@(posedge clock) disable iff (!resetn)
		s_q.st == sfc_pkg::SFC_SHUTDOWN |-> s_q.br == 2'b00)
		else $error("bridges driven in shutdown");
	a_shape_forced: assert property (@(posedge clock) disable iff (!resetn)
		s_q.st == sfc_pkg::SFC_TWO_PHASE && second_motion |=> s_q.shape)
		else $error("accel shape not forced");
	a_elec_or: assert property (@(posedge clock) disable iff (!resetn)
		##1 s_q.elec == $past(f_cp || f_uv || f_def || f_vdd))
		else $error("fault summary wrong");
	a_fault_stops: assert property (@(posedge clock) disable iff (!resetn)
		causes && s_q.st == sfc_pkg::SFC_STOPPED |=> s_q.st == sfc_pkg::SFC_SHUTDOWN)
		else $error("fault did not shut down");
	// a charge pump loss mid-move halts hard and marks the move as lost
	a_cp_step_lost: assert property (@(posedge clock) disable iff (!resetn)
		(s_q.st == sfc_pkg::SFC_MOVING || s_q.st == sfc_pkg::SFC_TWO_PHASE) && f_cp
		|=> s_q.st == sfc_pkg::SFC_IMM_HALT && s_q.step_lost)
		else $error("charge pump loss not halted");
	// motion starts from hold current straight into run current
	a_run_start: assert property (@(posedge clock) disable iff (!resetn)
		$past(s_q.st) == sfc_pkg::SFC_STOPPED && s_q.st == sfc_pkg::SFC_MOVING
		|-> s_q.cur == sfc_pkg::SFC_CUR_RUN && $past(s_q.cur) == sfc_pkg::SFC_CUR_HOLD)
		else $error("motion start current wrong");
	// in shutdown the target keeps following the position counter
	a_shutdown_copy: assert property (@(posedge clock) disable iff (!resetn)
		$past(resetn) && $past(s_q.st) == sfc_pkg::SFC_SHUTDOWN
		|-> s_q.tag == $past(actual_position))
		else $error("target not copied in shutdown");
endmodule // sfc_control
`default_nettype wire

/* dv/sfc_master_model.sv */
`default_nettype none
// behavioural bus master: turns bench requests into one-cycle command strobes
module sfc_master_model #(
	parameter int MAX_READS = 3 // recovery reads tried before giving up
) (
	input wire logic clock,
	input wire logic busy, // positioning move running
	input wire logic in_shutdown, // block reports motor shutdown
	output sfc_pkg::sfc_cmd_t cmd,
	output logic [7:0] param_byte7,
	output logic [10:0] cmd_position
);
	timeunit 1ns;
	timeprecision 100ps;
	// quiet bus at time zero
	initial begin
		cmd = '0;
		param_byte7 = 8'h00;
		cmd_position = 11'h000;
	end
	// one strobe launched just after an edge, taken at the next edge
	task automatic send(input logic [9:0] c, input logic [7:0] b7, input logic [10:0] p);
		@(posedge clock);
		#1;
		if (c[7] && busy) begin
			return;
		end
		cmd = sfc_pkg::sfc_cmd_t'(c);
		param_byte7 = b7;
		cmd_position = p;
		@(posedge clock);
		#1;
		cmd = '0;
		// data is stale now, so show its inverse rather than hold it
		param_byte7 = ~b7;
		cmd_position = ~p;
	endtask
	// bounded retries: each read releases the bridges only if every cause is gone
	task automatic recover();
		for (int i = 0; i < MAX_READS && in_shutdown; i++) begin
			send(10'h200, 8'h00, 11'h000);
			repeat (3) @(posedge clock);
		end
	endtask
endmodule // sfc_master_model
`default_nettype wire

/* dv/stepper_fault_shutdown_control_test.sv */
`default_nettype none
`include "sfc_params.svh"
module stepper_fault_shutdown_control_test;
	timeunit 1ns;
	timeprecision 100ps;
	// command strobe codes, bit order of the command struct
	localparam logic [9:0] C_READ = 10'h200, C_REST = 10'h100, C_MPAR = 10'h080;
	localparam logic [9:0] C_SPAR = 10'h040, C_SETT = 10'h020, C_GSEC = 10'h010;
	localparam logic [9:0] C_CLR = 10'h008, C_DUAL = 10'h004, C_HALT = 10'h002;
	logic clock, resetn;
	sfc_pkg::sfc_cmd_t cmd;
	logic [7:0] param_byte7, b, sb;
	sfc_pkg::sfc_vel_t ram_vel_in, dual_vel_in, status_vel, active_vel;
	logic [1:0] dual_vel_given, vdrop_bridge, bridge_enable;
	logic [10:0] cmd_position, secure_position, actual_position, target_position, p;
	logic [10:0] current_angle;
	logic motion_done, second_motion, accel_shape_bit, pwm_rate_select, pwm_dither_enable;
	sfc_pkg::sfc_mon_t mon;
	sfc_pkg::sfc_state_t state;
	sfc_pkg::sfc_flags_t flags;
	sfc_pkg::sfc_cur_t coil_current;
	logic [15:0] pwm_period, rnd;
	int n_mismatch = 0, tests_run = 0, cyc = 0;
	int mbit[5] = '{3, 5, 4, 2, 1}; // monitor bit per cause
	int fbit[5] = '{6, 8, 7, 5, 5}; // flag bit raised by that cause

	sfc_control sfc_control_i (.clock(clock), .resetn(resetn), .cmd(cmd),
		.param_byte7(param_byte7), .ram_vel_in(ram_vel_in), .dual_vel_in(dual_vel_in),
		.dual_vel_given(dual_vel_given), .cmd_position(cmd_position),
		.secure_position(secure_position), .actual_position(actual_position),
		.motion_done(motion_done), .second_motion(second_motion), .mon(mon),
		.vdrop_bridge(vdrop_bridge), .target_position(target_position), .state(state),
		.flags(flags), .status_vel(status_vel), .active_vel(active_vel),
		.accel_shape_bit(accel_shape_bit), .pwm_rate_select(pwm_rate_select),
		.pwm_dither_enable(pwm_dither_enable), .pwm_period(pwm_period),
		.coil_current(coil_current), .current_angle(current_angle),
		.bridge_enable(bridge_enable));
	sfc_master_model sfc_master_model_i (.clock(clock),
		.busy(state == sfc_pkg::SFC_MOVING), .in_shutdown(state == sfc_pkg::SFC_SHUTDOWN),
		.cmd(cmd), .param_byte7(param_byte7), .cmd_position(cmd_position));

	// 125 MHz clock
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	// hang guard, sized well above the longest fault wait
	always @(posedge clock) begin
		cyc++;
		if (cyc == 60000) begin
			n_mismatch++;
			$display("mismatch t=%0t run timed out", $time);
			test_done();
		end
	end
	// next pseudo-random word
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// expected pwm period for a rate select value
	function automatic logic [15:0] exp_period(input logic r);
		return r ? 16'(`SFC_PWM_FAST_CYC) : 16'(`SFC_PWM_SLOW_CYC);
	endfunction
	task automatic chk(input logic ok, input string m);
		tests_run++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("mismatch t=%0t %s", $time, m);
		end
	endtask
	// let n edges pass, then step off the edge
	task automatic idle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// bounded wait for a controller state
	task automatic wait_state(input sfc_pkg::sfc_state_t s, input int n);
		for (int i = 0; i < n && state !== s; i++) begin
			idle(1);
		end
		chk(state === s, "expected state not reached");
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		resetn = 1'b0;
		ram_vel_in = '0;
		dual_vel_in = '0;
		dual_vel_given = 2'h0;
		secure_position = 11'h400;
		actual_position = 11'h010;
		motion_done = 1'b0;
		second_motion = 1'b0;
		mon = '0;
		vdrop_bridge = 2'h0;
		rnd = 16'h004f;
		idle(20);
		resetn = 1'b1;
		// power-up: parked in shutdown until a status read
		chk(state === sfc_pkg::SFC_SHUTDOWN, "not in shutdown");
		idle(8);
		chk(flags.logic_supply_reset_flag === 1'b1, "reset flag low");
		chk(flags.elec_fault_flag === 1'b1, "summary low");
		chk(state === sfc_pkg::SFC_SHUTDOWN, "left without read");
		sfc_master_model_i.recover();
		idle(2);
		chk(state === sfc_pkg::SFC_STOPPED, "still down");
		chk(coil_current === sfc_pkg::SFC_CUR_HOLD, "no hold");
		chk(flags.elec_fault_flag === 1'b0, "summary stuck");
		// secure valid: most negative code, then 3ff, then random
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			secure_position = (i == 0) ? 11'h400 : (i == 1) ? 11'h3ff : rnd[10:0];
			idle(3);
			chk(flags.secure_position_valid === (secure_position != 11'h400), "sec");
		end
		// pwm rate and dither; stall write must move dither only
		for (int i = 0; i < 6; i++) begin
			rnd = lfsr(rnd);
			b = (i == 0) ? 8'h41 : (i == 1) ? 8'h00 : rnd[7:0];
			sfc_master_model_i.send(C_MPAR, b, 11'h000);
			idle(2);
			chk(pwm_rate_select === b[6] && pwm_dither_enable === b[0], "pwm");
			chk(pwm_period === exp_period(b[6]), "period");
			sb = {1'b0, ~b[6], 5'h00, ~b[0]};
			sfc_master_model_i.send(C_SPAR, sb, 11'h000);
			idle(2);
			chk(pwm_rate_select === b[6] && pwm_dither_enable === sb[0], "stall");
		end
		// two-phase move with only vmax supplied
		rnd = lfsr(rnd);
		ram_vel_in = rnd[7:0];
		sfc_master_model_i.send(C_MPAR, 8'h00, 11'h000);
		dual_vel_in = ~rnd[7:0];
		dual_vel_given = 2'h2;
		sfc_master_model_i.send(C_DUAL, 8'h00, 11'h000);
		idle(2);
		chk(active_vel === {~rnd[7:4], rnd[3:0]}, "dual params");
		chk(status_vel === rnd[7:0], "status vel");
		second_motion = 1'b1;
		sfc_master_model_i.send(C_REST, 8'h00, 11'h000);
		idle(2);
		chk(accel_shape_bit === 1'b1, "shape not forced");
		chk(status_vel === 8'h00, "ram not restored");
		second_motion = 1'b0;
		motion_done = 1'b1;
		wait_state(sfc_pkg::SFC_STOPPED, 50);
		motion_done = 1'b0;
		idle(2);
		chk(accel_shape_bit === 1'b0, "shape stuck");
		// move, hard halt, then blocked targets while step lost
		sfc_master_model_i.send(C_SETT, 8'h00, 11'h055);
		wait_state(sfc_pkg::SFC_MOVING, 3000);
		idle(1);
		chk(coil_current === sfc_pkg::SFC_CUR_RUN, "no run current");
		sfc_master_model_i.send(C_HALT, 8'h00, 11'h000);
		wait_state(sfc_pkg::SFC_IMM_HALT, 4);
		idle(1);
		chk(flags.step_lost_flag === 1'b1, "no step lost");
		motion_done = 1'b1;
		wait_state(sfc_pkg::SFC_STOPPED, 10);
		motion_done = 1'b0;
		chk(flags.halt_exit_flag === 1'b1, "halt exit low");
		chk(coil_current === sfc_pkg::SFC_CUR_STAB, "no stabilise");
		idle(1);
		chk(flags.halt_exit_flag === 1'b0, "halt exit stuck");
		p = target_position;
		secure_position = 11'h155;
		sfc_master_model_i.send(C_SETT, 8'h00, 11'h2aa);
		sfc_master_model_i.send(C_GSEC, 8'h00, 11'h000);
		idle(2);
		chk(target_position === p, "target moved");
		actual_position = 11'h000;
		sfc_master_model_i.send(C_CLR, 8'h00, 11'h000);
		idle(3);
		chk(target_position === 11'h000 && flags.step_lost_flag === 1'b1, "clear");
		sfc_master_model_i.send(C_READ, 8'h00, 11'h000);
		idle(2);
		chk(flags.step_lost_flag === 1'b0, "step lost stuck");
		for (int i = 0; i < 3000 && coil_current !== sfc_pkg::SFC_CUR_HOLD; i++) begin
			idle(1);
		end
		chk(coil_current === sfc_pkg::SFC_CUR_HOLD && current_angle === 11'h000, "hold");
		sfc_master_model_i.send(C_SETT, 8'h00, 11'h0aa);
		idle(2);
		chk(target_position === 11'h0aa, "target refused");
		// each shutdown cause; charge pump first, while moving
		for (int k = 0; k < 5; k++) begin
			rnd = lfsr(rnd);
			if (k == 0) begin
				wait_state(sfc_pkg::SFC_MOVING, 3000);
			end
			actual_position = rnd[10:0];
			vdrop_bridge = 2'h1;
			mon[mbit[k]] = 1'b1;
			// the hard halt must come before the ramp is declared done
			if (k == 0) begin
				wait_state(sfc_pkg::SFC_IMM_HALT, 6);
			end
			// a drop opens only its own bridge until shutdown takes both
			if (k == 3) begin
				idle(2);
				chk(bridge_enable === 2'h2, "drop bridge");
			end
			motion_done = 1'b1;
			wait_state(sfc_pkg::SFC_SHUTDOWN, 13000);
			motion_done = 1'b0;
			idle(1);
			chk(flags[fbit[k]] === 1'b1 && bridge_enable === 2'h0, "fault");
			chk(flags.elec_fault_flag === (k != 1), "summary");
			chk(target_position === actual_position, "target copy");
			if (k == 0) begin
				chk(flags.step_lost_flag === 1'b1, "cp step lost");
			end
			sfc_master_model_i.send(C_READ, 8'h00, 11'h000);
			idle(3);
			chk(state === sfc_pkg::SFC_SHUTDOWN, "left with cause");
			mon = '0;
			idle(3);
			sfc_master_model_i.recover();
			idle(2);
			chk(state === sfc_pkg::SFC_STOPPED && flags[fbit[k]] === 1'b0, "exit");
		end
		test_done();
	end
endmodule // stepper_fault_shutdown_control_test
`default_nettype wire
